// [pcp_checker.sv]
// Port checks for the pulse counter channel
`timescale 1ns/1ps
`default_nettype none
module pcp_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Field pins
  input wire logic        pulse_second,
  input wire logic        index_input,
  input wire logic        limit_switch_input,
  input wire logic [1:0]  trig_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_rd;
    psel && penable && pready && !pwrite;
  endsequence
  sequence s_stat;
    s_rd ##0 paddr == pcp_pkg::OFS_STATUS;
  endsequence
  a_one_wait: assert property (s_wait |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_err: assert property (
    s_rd ##0 paddr > pcp_pkg::OFS_OUT_EN |-> pslverr)
    else $error("no pslverr");
  a_preset_hidden: assert property (
    s_rd ##0 paddr == pcp_pkg::OFS_PRESET |-> prdata == 32'h0000_0000)
    else $error("preset readable");
  // Long stable spans cover the two-flop synchroniser delay
  a_second_level: assert property (
    $stable(pulse_second)[*6] ##0 s_stat |-> prdata[pcp_pkg::ST_SECOND] == pulse_second)
    else $error("second status");
  a_index_level: assert property (
    $stable(index_input)[*6] ##0 s_stat |-> prdata[pcp_pkg::ST_INDEX] == index_input)
    else $error("index status");
  a_limit_level: assert property (
    $stable(limit_switch_input)[*6] ##0 s_stat |-> prdata[pcp_pkg::ST_LIMIT] == limit_switch_input)
    else $error("limit status");
  a_trig_status: assert property (
    $stable(trig_out)[*3] ##0 s_stat |-> prdata[pcp_pkg::ST_TRIG1:pcp_pkg::ST_TRIG0] == trig_out)
    else $error("trig status");
endmodule
bind pcp_counter_top pcp_checker pcp_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pulse_second, .index_input, .limit_switch_input,
  .trig_out);
`default_nettype wire

// [pcp_counter_top.sv]
// Pulse counter channel with preset, freeze, window total and triggered outputs
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcp_counter_top #(
  parameter int unsigned WIN_LONG_CYC  = pcp_pkg::CLK_HZ / pcp_pkg::MS_PER_S
                                         * pcp_pkg::WIN_LONG_MS,
  parameter int unsigned WIN_SHORT_CYC = pcp_pkg::CLK_HZ / pcp_pkg::MS_PER_S
                                         * pcp_pkg::WIN_SHORT_MS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Field inputs
  input  wire logic        pulse_first,
  input  wire logic        pulse_second,
  input  wire logic        index_input,
  input  wire logic        limit_switch_input,
  // Triggered outputs
  output logic      [1:0]  trig_out
);
  typedef struct packed {
    logic [1:0]  a_sync;
    logic [1:0]  b_sync;
    logic [1:0]  z_sync;
    logic [1:0]  l_sync;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] count;
    logic [7:0]  mode;
    logic [7:0]  win_sel;
    logic        idx_en;
    logic        lim_en;
    logic        freeze;
    logic [31:0] preset;
    logic [31:0] on0;
    logic [31:0] off0;
    logic [31:0] on1;
    logic [31:0] off1;
    logic [1:0]  out_en;
    logic [1:0]  trig;
  } pcp_top_t;

  pcp_top_t    st;
  pcp_top_t    next_st;
  logic [31:0] win_total;
  logic        in_a;
  logic        in_b;
  logic        in_z;
  logic        in_l;
  logic        wr_take;
  logic        rd_start;
  logic        force_hit;
  logic        load_preset;

  pcp_evt_if evt ();

  pcp_pulse_decode u_decode (
    .pclk    (pclk),
    .presetn (presetn),
    .in_a    (in_a),
    .in_b    (in_b),
    .mode    (st.mode),
    .evt     (evt)
  );

  pcp_window_measure #(
    .LONG_CYC  (WIN_LONG_CYC),
    .SHORT_CYC (WIN_SHORT_CYC)
  ) u_window (
    .pclk    (pclk),
    .presetn (presetn),
    .count   (st.count),
    .win_sel (st.win_sel),
    .total   (win_total)
  );

  // Address map check
  function automatic logic addr_mapped(input logic [7:0] a);
    if (a == pcp_pkg::OFS_COUNT) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_TOTAL) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_STATUS) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_CONFIG) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_PRESET) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_FORCE) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_ON0 || a == pcp_pkg::OFS_OFF0) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_ON1 || a == pcp_pkg::OFS_OFF1) begin
      addr_mapped = 1'b1;
    end else if (a == pcp_pkg::OFS_OUT_EN) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction

  // Read data for one address; write-only words read as zero
  function automatic logic [31:0] read_word(input logic [7:0] a, input pcp_top_t s,
                                            input logic [31:0] tot);
    read_word = pcp_pkg::ZERO_WORD;
    if (a == pcp_pkg::OFS_COUNT) begin
      read_word = s.count;
    end else if (a == pcp_pkg::OFS_TOTAL) begin
      read_word = tot;
    end else if (a == pcp_pkg::OFS_STATUS) begin
      read_word[pcp_pkg::ST_FIRST]  = s.a_sync[1];
      read_word[pcp_pkg::ST_SECOND] = s.b_sync[1];
      read_word[pcp_pkg::ST_INDEX]  = s.z_sync[1];
      read_word[pcp_pkg::ST_LIMIT]  = s.l_sync[1];
      read_word[pcp_pkg::ST_TRIG0]  = s.trig[0];
      read_word[pcp_pkg::ST_TRIG1]  = s.trig[1];
    end else if (a == pcp_pkg::OFS_CONFIG) begin
      read_word[pcp_pkg::CF_MODE_LSB +: 8] = s.mode;
      read_word[pcp_pkg::CF_WIN_LSB +: 8]  = s.win_sel;
    end else begin
      read_word = pcp_pkg::ZERO_WORD;
    end
  endfunction

  // Next state of one triggered output; on-value wins if both match
  function automatic logic trig_next(input logic en, input logic cur, input logic [31:0] cnt,
                                     input logic [31:0] on_v, input logic [31:0] off_v);
    if (!en) begin
      trig_next = 1'b0;
    end else if (cnt == on_v) begin
      trig_next = 1'b1;
    end else if (cnt == off_v) begin
      trig_next = 1'b0;
    end else begin
      trig_next = cur;
    end
  endfunction

  always_comb begin
    next_st = st;
    // Two flops on each pin before anything looks at it
    next_st.a_sync = {st.a_sync[0], pulse_first};
    next_st.b_sync = {st.b_sync[0], pulse_second};
    next_st.z_sync = {st.z_sync[0], index_input};
    next_st.l_sync = {st.l_sync[0], limit_switch_input};
    in_a = st.a_sync[1];
    in_b = st.b_sync[1];
    in_z = st.z_sync[1];
    in_l = st.l_sync[1];

    // One wait state: pready rises in the second access cycle
    rd_start = psel & penable & ~st.pready;
    wr_take  = psel & penable & st.pready & pwrite;
    next_st.pready  = rd_start;
    next_st.pslverr = rd_start & ~addr_mapped(paddr);
    next_st.prdata  = rd_start && !pwrite ? read_word(paddr, st, win_total)
                                          : pcp_pkg::ZERO_WORD;

    force_hit = wr_take && paddr == pcp_pkg::OFS_FORCE && pwdata[pcp_pkg::CF_FORCE];
    if (wr_take) begin
      if (paddr == pcp_pkg::OFS_CONFIG) begin
        next_st.mode    = pwdata[pcp_pkg::CF_MODE_LSB +: 8];
        next_st.win_sel = pwdata[pcp_pkg::CF_WIN_LSB +: 8];
        next_st.idx_en  = pwdata[pcp_pkg::CF_IDX_EN];
        next_st.lim_en  = pwdata[pcp_pkg::CF_LIM_EN];
        next_st.freeze  = pwdata[pcp_pkg::CF_FREEZE];
      end else if (paddr == pcp_pkg::OFS_PRESET) begin
        next_st.preset = pwdata;
      end else if (paddr == pcp_pkg::OFS_ON0) begin
        next_st.on0 = pwdata;
      end else if (paddr == pcp_pkg::OFS_OFF0) begin
        next_st.off0 = pwdata;
      end else if (paddr == pcp_pkg::OFS_ON1) begin
        next_st.on1 = pwdata;
      end else if (paddr == pcp_pkg::OFS_OFF1) begin
        next_st.off1 = pwdata;
      end else if (paddr == pcp_pkg::OFS_OUT_EN) begin
        next_st.out_en = pwdata[1:0];
      end
    end

    // Index or limit held high, with its enable bit set, keeps the count pinned at the preset
    load_preset = force_hit | (in_z & st.idx_en) | (in_l & st.lim_en);
    if (load_preset) begin
      next_st.count = st.preset;
    end else if (st.freeze) begin
      next_st.count = st.count;
    end else if (evt.up) begin
      next_st.count = st.count + 32'h0000_0001;
    end else if (evt.down) begin
      next_st.count = st.count - 32'h0000_0001;
    end

    next_st.trig[0] = trig_next(st.out_en[0], st.trig[0], st.count, st.on0, st.off0);
    next_st.trig[1] = trig_next(st.out_en[1], st.trig[1], st.count, st.on1, st.off1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.preset <= pcp_pkg::PRESET_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign trig_out = st.trig;
endmodule
`default_nettype wire

// [pcp_evt_if.sv]
// Count events passed from the input decoder to the counter
`timescale 1ns/1ps
`default_nettype none
interface pcp_evt_if;
  logic up;
  logic down;
  modport src (output up, output down);
  modport dst (input up, input down);
endinterface
`default_nettype wire

// [pcp_field_src.sv]
// Field pulse source: encoder, pulse train and switch levels
`timescale 1ns/1ps
`default_nettype none
module pcp_field_src (
  // Clock
  input  wire logic pclk,
  // Field pins
  output logic      pulse_first,
  output logic      pulse_second,
  output logic      index_input,
  output logic      limit_switch_input
);
  initial begin
    pulse_first = 1'b0;
    pulse_second = 1'b0;
    index_input = 1'b0;
    limit_switch_input = 1'b0;
  end
  // Levels outlast the synchroniser, as a slow field source would
  task automatic hold();
    repeat (5) @(posedge pclk);
  endtask
  // One count event in mode m, upward when up is set
  task automatic step(input logic [7:0] m, input logic up);
    hold();
    case (m)
      pcp_pkg::MODE_PULSE_DIR: begin
        pulse_first <= 1'b0;
        pulse_second <= up;
        hold();
        pulse_first <= 1'b1;
        hold();
        pulse_first <= 1'b0;
      end
      pcp_pkg::MODE_UP_DOWN: begin
        pulse_first <= up;
        pulse_second <= !up;
        hold();
        pulse_first <= 1'b0;
        pulse_second <= 1'b0;
      end
      default: begin
        // Gray step, first phase leads when counting up
        pulse_first <= up ? !pulse_second : pulse_second;
        pulse_second <= up ? pulse_first : !pulse_first;
      end
    endcase
    hold();
  endtask
  task automatic levels(input logic idx, input logic lim);
    hold();
    index_input <= idx;
    limit_switch_input <= lim;
    hold();
  endtask
endmodule
`default_nettype wire

// [pcp_pkg.sv]
// Shared constants for the pulse counter channel
package pcp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_COUNT    = 8'h00;
  localparam logic [7:0] OFS_TOTAL    = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_CONFIG   = 8'h0C;
  localparam logic [7:0] OFS_PRESET   = 8'h10;
  localparam logic [7:0] OFS_FORCE    = 8'h14;
  localparam logic [7:0] OFS_ON0      = 8'h18;
  localparam logic [7:0] OFS_OFF0     = 8'h1C;
  localparam logic [7:0] OFS_ON1      = 8'h20;
  localparam logic [7:0] OFS_OFF1     = 8'h24;
  localparam logic [7:0] OFS_OUT_EN   = 8'h28;

  // Status bit positions
  localparam int unsigned ST_FIRST    = 0;
  localparam int unsigned ST_SECOND   = 1;
  localparam int unsigned ST_INDEX    = 2;
  localparam int unsigned ST_LIMIT    = 3;
  localparam int unsigned ST_TRIG0    = 4;
  localparam int unsigned ST_TRIG1    = 5;

  // Configuration field positions
  localparam int unsigned CF_MODE_LSB = 0;
  localparam int unsigned CF_WIN_LSB  = 8;
  localparam int unsigned CF_IDX_EN   = 16;
  localparam int unsigned CF_LIM_EN   = 17;
  localparam int unsigned CF_FREEZE   = 18;
  localparam int unsigned CF_FORCE    = 0;

  // Count modes
  localparam logic [7:0] MODE_PULSE_DIR = 8'h00;
  localparam logic [7:0] MODE_UP_DOWN   = 8'h01;
  localparam logic [7:0] MODE_QUAD      = 8'h02;

  // Window selection
  localparam logic [7:0] WIN_SEL_LONG  = 8'h00;
  localparam logic [7:0] WIN_SEL_SHORT = 8'h01;

  // Reset values
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  // Timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned WIN_LONG_MS  = 1000;
  localparam int unsigned WIN_SHORT_MS = 200;
  localparam int unsigned MS_PER_S     = 1000;
endpackage

// [pcp_pulse_decode.sv]
// Turns the two synchronised pulse inputs into up and down events
`timescale 1ns/1ps
`default_nettype none
module pcp_pulse_decode (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Synchronised inputs
  input  wire logic       in_a,
  input  wire logic       in_b,
  input  wire logic [7:0] mode,
  // Events out
  pcp_evt_if.src          evt
);
  typedef struct packed {
    logic pa;
    logic pb;
    logic up;
    logic down;
  } pcp_dec_t;

  pcp_dec_t st;
  pcp_dec_t next_st;
  logic     rise_a;
  logic     rise_b;
  logic     quad_step;
  logic     quad_dir;

  always_comb begin
    next_st    = st;
    next_st.pa = in_a;
    next_st.pb = in_b;
    rise_a     = in_a & ~st.pa;
    rise_b     = in_b & ~st.pb;
    // Any single edge of either phase is one step
    quad_step  = in_a ^ st.pa ^ in_b ^ st.pb;
    quad_dir   = in_a ^ st.pb;
    next_st.up   = 1'b0;
    next_st.down = 1'b0;
    case (mode)
      pcp_pkg::MODE_PULSE_DIR: begin
        // First input counts, second gives direction
        next_st.up   = rise_a & in_b;
        next_st.down = rise_a & ~in_b;
      end
      pcp_pkg::MODE_UP_DOWN: begin
        // Simultaneous edges cancel
        next_st.up   = rise_a & ~rise_b;
        next_st.down = rise_b & ~rise_a;
      end
      pcp_pkg::MODE_QUAD: begin
        // Phase order sets direction
        next_st.up   = quad_step & quad_dir;
        next_st.down = quad_step & ~quad_dir;
      end
      default: begin
        next_st.up   = 1'b0;
        next_st.down = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt.up   = st.up;
  assign evt.down = st.down;
endmodule
`default_nettype wire

// [pcp_window_measure.sv]
// Measures how far the count moved over each timed window
`timescale 1ns/1ps
`default_nettype none
module pcp_window_measure #(
  parameter int unsigned LONG_CYC  = 100_000_000,
  parameter int unsigned SHORT_CYC = 20_000_000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Count and selection
  input  wire logic [31:0] count,
  input  wire logic [7:0]  win_sel,
  // Result
  output logic      [31:0] total
);
  typedef struct packed {
    logic [31:0] timer;
    logic [31:0] start;
    logic [31:0] total;
    logic [7:0]  sel;
  } pcp_win_t;

  pcp_win_t    st;
  pcp_win_t    next_st;
  logic [31:0] last_tick;

  always_comb begin
    next_st = st;
    // Value 1 picks the short window, anything else the long one
    last_tick = (win_sel == pcp_pkg::WIN_SEL_SHORT) ? 32'(SHORT_CYC - 1) : 32'(LONG_CYC - 1);
    next_st.sel = win_sel;
    if (win_sel != st.sel) begin
      // New length restarts the window so no mixed-length result appears
      next_st.timer = pcp_pkg::ZERO_WORD;
      next_st.start = count;
    end else if (st.timer >= last_tick) begin
      next_st.timer = pcp_pkg::ZERO_WORD;
      next_st.total = count - st.start;
      next_st.start = count;
    end else begin
      next_st.timer = st.timer + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign total = st.total;
endmodule
`default_nettype wire

// [tb_pulse_counter_preset_trigger.sv]
// Self-checking bench for the pulse counter channel
`timescale 1ns/1ps
`default_nettype none
module tb_pulse_counter_preset_trigger;
  // Short windows keep the run brief
  localparam int LONG_CYC  = 600;
  localparam int SHORT_CYC = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pulse_first, pulse_second, index_input, limit_switch_input;
  logic [1:0]  trig_out;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;

  pcp_counter_top #(.WIN_LONG_CYC(LONG_CYC), .WIN_SHORT_CYC(SHORT_CYC)) pcp_counter_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pulse_first, .pulse_second, .index_input, .limit_switch_input, .trig_out);
  pcp_field_src pcp_field_src_inst (
    .pclk, .pulse_first, .pulse_second, .index_input, .limit_switch_input);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Ready and data are taken at the rising edge, before that edge updates them
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    if (pready !== 1'b1) test_done();
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cnt(input logic [31:0] e);
    rd(pcp_pkg::OFS_COUNT);
    chk("count", e, rd_q);
  endtask
  task automatic ev(input logic [7:0] m, input logic up, input int n);
    repeat (n) pcp_field_src_inst.step(m, up);
  endtask
  task automatic force_to(input logic [31:0] v);
    wr(pcp_pkg::OFS_PRESET, v);
    wr(pcp_pkg::OFS_FORCE, 32'h0000_0001);
  endtask

  task automatic t_reset();
    rd(pcp_pkg::OFS_CONFIG);
    chk("config", 32'h0000_0000, rd_q);
    rd(pcp_pkg::OFS_PRESET);
    chk("preset read", 32'h0000_0000, rd_q);
    cnt(32'h0000_0000);
    ev(pcp_pkg::MODE_PULSE_DIR, 1'b1, 1);
    cnt(32'h0000_0001);
    wr(pcp_pkg::OFS_FORCE, 32'h0000_0001);
    cnt(32'h0000_0000);
    rd(8'h40);
    chk("unmapped", 32'h1, 32'(rd_err));
    $display("reset test done");
  endtask
  // Wraps upward through zero, then steps back down to zero, in every mode
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      wr(pcp_pkg::OFS_CONFIG, 32'(m));
      force_to(32'hFFFF_FFFE);
      cnt(32'hFFFF_FFFE);
      ev(8'(m), 1'b1, 3);
      cnt(32'h0000_0001);
      rd(pcp_pkg::OFS_STATUS);
      chk("second", 32'(pulse_second), 32'(rd_q[pcp_pkg::ST_SECOND]));
      ev(8'(m), 1'b0, 1);
      cnt(32'h0000_0000);
    end
    // A mode value outside the three must not count
    wr(pcp_pkg::OFS_CONFIG, 32'h0000_0003);
    ev(pcp_pkg::MODE_PULSE_DIR, 1'b1, 1);
    cnt(32'h0000_0000);
    $display("mode test done");
  endtask
  task automatic t_hold();
    wr(pcp_pkg::OFS_CONFIG, 32'h0004_0000);
    ev(pcp_pkg::MODE_PULSE_DIR, 1'b1, 2);
    cnt(32'h0000_0000);
    wr(pcp_pkg::OFS_FORCE, 32'h0000_0000);
    cnt(32'h0000_0000);
    wr(pcp_pkg::OFS_CONFIG, 32'h0000_0000);
    ev(pcp_pkg::MODE_PULSE_DIR, 1'b1, 1);
    cnt(32'h0000_0001);
    $display("hold test done");
  endtask
  task automatic t_pins();
    for (int i = 0; i < 2; i++) begin
      wr(pcp_pkg::OFS_PRESET, 32'h0000_0055 + 32'(i));
      pcp_field_src_inst.levels(i == 0, i == 1);
      rd(pcp_pkg::OFS_STATUS);
      chk("pin status", 32'h1, 32'(rd_q[pcp_pkg::ST_INDEX + i]));
      cnt(i ? 32'h0000_0055 : 32'h0000_0001);
      wr(pcp_pkg::OFS_CONFIG, 32'h0001_0000 << i);
      cnt(32'h0000_0055 + 32'(i));
      pcp_field_src_inst.levels(1'b0, 1'b0);
      wr(pcp_pkg::OFS_CONFIG, 32'h0000_0000);
    end
    $display("pin test done");
  endtask
  task automatic t_trig();
    logic [1:0] e;
    wr(pcp_pkg::OFS_ON0, 32'h0000_0005);
    wr(pcp_pkg::OFS_OFF0, 32'h0000_0008);
    wr(pcp_pkg::OFS_ON1, 32'h0000_0005);
    wr(pcp_pkg::OFS_OFF1, 32'h0000_0008);
    wr(pcp_pkg::OFS_OUT_EN, 32'h0000_0001);
    force_to(32'h0000_0003);
    for (int k = 4; k < 10; k++) begin
      ev(pcp_pkg::MODE_PULSE_DIR, 1'b1, 1);
      e = (k >= 5 && k < 8) ? 2'h1 : 2'h0;
      chk("trig out", 32'(e), 32'(trig_out));
      rd(pcp_pkg::OFS_STATUS);
      chk("trig status", 32'(e), 32'(rd_q[pcp_pkg::ST_TRIG1:pcp_pkg::ST_TRIG0]));
    end
    $display("trigger test done");
  endtask
  task automatic wait_total(input logic [31:0] e, output int t);
    int n;
    n = 0;
    do begin
      rd(pcp_pkg::OFS_TOTAL);
      n++;
    end while (rd_q !== e && n < 500);
    t = cyc;
    chk("total", e, rd_q);
    if (rd_q !== e) test_done();
  endtask
  // Reset in mid-run clears triggers, count, config and preset
  task automatic t_rerst();
    force_to(32'h0000_0005);
    repeat (3) @(posedge pclk);
    chk("trig before reset", 32'h1, 32'(trig_out));
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("trig after reset", 32'h0, 32'(trig_out));
    rd(pcp_pkg::OFS_CONFIG);
    chk("config after reset", 32'h0000_0000, rd_q);
    cnt(32'h0000_0000);
    wr(pcp_pkg::OFS_FORCE, 32'h0000_0001);
    cnt(32'h0000_0000);
    $display("mid-run reset test done");
  endtask
  // Select changes restart the window; the short one runs first
  task automatic t_win();
    int t0, t1, t2, w;
    for (int s = 1; s >= 0; s--) begin
      w = s ? SHORT_CYC : LONG_CYC;
      force_to(32'h0000_0010);
      wr(pcp_pkg::OFS_CONFIG, 32'(s) << 8);
      t0 = cyc;
      force_to(32'h0000_1010);
      wait_total(32'h0000_1000, t1);
      force_to(32'h0000_000F);
      wait_total(32'hFFFF_EFFF, t2);
      chk("first span", 32'h1, 32'(t1 - t0 >= w - 12 && t1 - t0 <= w + 12));
      chk("next span", 32'h1, 32'(t2 - t1 >= w - 12 && t2 - t1 <= w + 12));
    end
    $display("window test done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_hold();
    t_pins();
    t_trig();
    t_rerst();
    t_win();
    test_done();
  end
endmodule
`default_nettype wire
